// [design/sfp_pin_front.sv]
// pin front end of a serial flash: select, pause, lane shifting
// assumes the serial clock is below a quarter of clk_i and that the
// instruction decoder behind it steers lane width and direction
`timescale 1ns/1ns

module sfp_pin_front #(
  parameter int DATA_W = 8 // byte width seen by the decoder
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire sfp_pkg::sfp_pins_in_t pins_i,
  output sfp_pkg::sfp_pins_out_t pins_o,
  input wire logic quad_enable_i,
  input wire logic quad_instruction_mode_i,
  input wire sfp_pkg::sfp_lane_t lane_mode_i,
  input wire logic tx_en_i,
  input wire logic [DATA_W-1:0] tx_byte_i,
  input wire logic busy_i,
  input wire logic status_protect_i,
  output logic [DATA_W-1:0] rx_byte_o,
  output logic rx_valid_o,
  output logic rx_first_o,
  output logic tx_req_o,
  output logic frame_abort_o,
  output logic selected_o,
  output logic paused_o,
  output logic standby_o,
  output logic status_write_block_o,
  output logic quad_refused_o
);
  import sfp_pkg::*;
  // ==========================================================
  // elaboration check
  // the lane slicing below is written for byte wide transfers
  if (DATA_W != SFP_BYTE_W) begin : g_bad_width
    $error("sfp_pin_front: DATA_W must be 8");
  end
  // ==========================================================
  // pin synchronisers
  logic [SFP_SYNC_W-1:0] sync1_reg; // first stage, read by sync2 only
  logic [SFP_SYNC_W-1:0] sync2_reg; // second stage, safe to use
  logic sclk_prev_reg; // previous synchronised clock level

  // two flops on every pin, then one more for clock edges
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg <= SFP_SYNC_RST;
      sync2_reg <= SFP_SYNC_RST;
      sclk_prev_reg <= SFP_SYNC_RST[SFP_POS_SCLK]; // no false edge
    end else begin
      sync1_reg <= {pins_i.cs_n, pins_i.sclk, pins_i.io};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[SFP_POS_SCLK];
    end
  end
  // ==========================================================
  // decoded pin view
  logic cs_n_s; // synchronised chip select
  logic sclk_s; // synchronised serial clock
  logic [3:0] io_s; // synchronised data lines
  logic sclk_rise; // rising serial clock edge seen
  logic sclk_fall; // falling serial clock edge seen
  logic wp_n_s; // write-protect level, low means protect
  logic pause_n_s; // pause level, low means pause
  logic qpi_on; // quad instruction mode in force
  logic quad_req; // decoder asks for four lanes
  logic quad_ok; // four lanes may really be used
  sfp_lane_t lane_eff; // lane width actually used
  logic [3:0] step; // bits moved per clock edge
  logic pause_want; // pause asked and allowed now

  always_comb begin
    cs_n_s = sync2_reg[SFP_POS_CS];
    sclk_s = sync2_reg[SFP_POS_SCLK];
    io_s = sync2_reg[3:0];
    // edges from the sampled clock; either idle level is fine
    sclk_rise = sclk_s & ~sclk_prev_reg;
    sclk_fall = ~sclk_s & sclk_prev_reg;
    // pins 2 and 3 are plain controls only without quad_enable
    wp_n_s = io_s[2] | quad_enable_i;
    pause_n_s = io_s[3] | quad_enable_i;
    // quad instruction mode needs quad_enable
    qpi_on = quad_instruction_mode_i & quad_enable_i;
    quad_req = quad_instruction_mode_i | (lane_mode_i == SFP_LANE_QUAD);
    quad_ok = quad_req & quad_enable_i;
    // refused quad work falls back to the dual lanes if lane_mode_i asks them, else the single line
    if (quad_ok) begin
      lane_eff = SFP_LANE_QUAD;
    end else if (lane_mode_i == SFP_LANE_DUAL) begin
      lane_eff = SFP_LANE_DUAL;
    end else begin
      lane_eff = SFP_LANE_SINGLE;
    end
    case (lane_eff)
      SFP_LANE_DUAL: step = 4'h2;
      SFP_LANE_QUAD: step = 4'h4;
      default: step = 4'h1;
    endcase
    // never pause during quad or quad instruction work
    pause_want = ~pause_n_s & ~quad_ok & ~qpi_on;
  end
  // ==========================================================
  // link state and shift logic
  sfp_state_t state_reg, state_next; // link state
  logic [2:0] bit_cnt_reg, bit_cnt_next; // bits of current byte
  logic [7:0] rx_sh_reg, rx_sh_next; // incoming bits
  logic [7:0] tx_sh_reg, tx_sh_next; // outgoing bits
  logic tx_act_reg, tx_act_next; // device drives the lines
  logic first_reg, first_next; // next byte is the instruction
  logic [7:0] rx_byte_reg, rx_byte_next;
  logic rx_valid_reg, rx_valid_next;
  logic rx_first_reg, rx_first_next;
  logic tx_req_reg, tx_req_next;
  logic abort_reg, abort_next;
  logic [3:0] io_out_reg, io_out_next;
  logic [3:0] oe_reg, oe_next;
  logic [3:0] sum; // bit count after this edge
  logic [7:0] rx_cat; // receive register with new bits
  // next-state and shifting for one system clock
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_sh_next = rx_sh_reg;
    tx_sh_next = tx_sh_reg;
    tx_act_next = tx_act_reg;
    first_next = first_reg;
    rx_byte_next = rx_byte_reg;
    rx_valid_next = 1'b0;
    rx_first_next = rx_first_reg;
    tx_req_next = 1'b0;
    abort_next = 1'b0;
    io_out_next = io_out_reg;
    oe_next = oe_reg;
    sum = {1'b0, bit_cnt_reg} + step;
    // new bits enter at the bottom, msb first on every lane
    case (lane_eff)
      SFP_LANE_DUAL: rx_cat = {rx_sh_reg[5:0], io_s[1:0]};
      SFP_LANE_QUAD: rx_cat = {rx_sh_reg[3:0], io_s};
      default: rx_cat = {rx_sh_reg[6:0], io_s[0]};
    endcase
    case (state_reg)
      SFP_ST_POWERUP: begin
        // no select counts until chip select was seen high
        if (cs_n_s) begin
          state_next = SFP_ST_IDLE;
        end
      end
      SFP_ST_IDLE: begin
        // high-to-low select opens a fresh instruction
        if (!cs_n_s) begin
          state_next = SFP_ST_ACTIVE;
          bit_cnt_next = SFP_BIT_CNT_RST;
          first_next = 1'b1;
          tx_act_next = 1'b0;
        end
      end
      SFP_ST_ACTIVE, SFP_ST_PAUSED: begin
        if (cs_n_s) begin
          // deselect: float all lines, drop partial bits
          state_next = SFP_ST_IDLE;
          abort_next = (bit_cnt_reg != SFP_BIT_CNT_RST);
          bit_cnt_next = SFP_BIT_CNT_RST;
          tx_act_next = 1'b0;
          oe_next = SFP_LANE_RST;
        end else if (state_reg == SFP_ST_PAUSED) begin
          // clock and data ignored; counters hold their place
          oe_next = SFP_LANE_RST;
          if (!pause_want && !sclk_s) begin
            state_next = SFP_ST_ACTIVE;
            // restore the lines that were driven before
            if (tx_act_reg) begin
              case (lane_eff)
                SFP_LANE_QUAD: oe_next = 4'hf;
                SFP_LANE_DUAL: oe_next = 4'h3;
                default: oe_next = 4'h2;
              endcase
            end
          end
        end else begin
          if (sclk_rise) begin
            // sample on the rising edge
            rx_sh_next = rx_cat;
            bit_cnt_next = sum[2:0];
            if (sum[3]) begin
              // byte boundary
              if (!tx_act_reg) begin
                rx_byte_next = rx_cat;
                rx_valid_next = 1'b1;
                rx_first_next = first_reg;
                first_next = 1'b0;
              end
              tx_act_next = tx_en_i;
              if (tx_en_i) begin
                tx_sh_next = tx_byte_i;
                tx_req_next = 1'b1;
              end
            end
          end
          if (sclk_fall && tx_act_reg) begin
            // drive on the falling edge, msb first
            case (lane_eff)
              SFP_LANE_QUAD: begin
                io_out_next = tx_sh_reg[7:4];
                oe_next = 4'hf;
                tx_sh_next = {tx_sh_reg[3:0], 4'h0};
              end
              SFP_LANE_DUAL: begin
                io_out_next = {2'b00, tx_sh_reg[7:6]};
                oe_next = 4'h3;
                tx_sh_next = {tx_sh_reg[5:0], 2'b00};
              end
              default: begin
                io_out_next = {2'b00, tx_sh_reg[7], 1'b0};
                oe_next = 4'h2;
                tx_sh_next = {tx_sh_reg[6:0], 1'b0};
              end
            endcase
          end else if (sclk_fall) begin
            // input phase: release the lines at the turn
            oe_next = SFP_LANE_RST;
          end
          // pause takes hold only with the clock low
          if (pause_want && !sclk_s) begin
            state_next = SFP_ST_PAUSED;
            oe_next = SFP_LANE_RST;
          end
        end
      end
      default: begin
        state_next = SFP_ST_POWERUP;
        oe_next = SFP_LANE_RST;
      end
    endcase
  end

  // registers of the link state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= SFP_ST_POWERUP;
      bit_cnt_reg <= SFP_BIT_CNT_RST;
      rx_sh_reg <= SFP_BYTE_RST;
      tx_sh_reg <= SFP_BYTE_RST;
      tx_act_reg <= 1'b0;
      first_reg <= 1'b0;
      rx_byte_reg <= SFP_BYTE_RST;
      rx_valid_reg <= 1'b0;
      rx_first_reg <= 1'b0;
      tx_req_reg <= 1'b0;
      abort_reg <= 1'b0;
      io_out_reg <= SFP_LANE_RST;
      oe_reg <= SFP_LANE_RST;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg <= rx_sh_next;
      tx_sh_reg <= tx_sh_next;
      tx_act_reg <= tx_act_next;
      first_reg <= first_next;
      rx_byte_reg <= rx_byte_next;
      rx_valid_reg <= rx_valid_next;
      rx_first_reg <= rx_first_next;
      tx_req_reg <= tx_req_next;
      abort_reg <= abort_next;
      io_out_reg <= io_out_next;
      oe_reg <= oe_next;
    end
  end
  // ==========================================================
  // status flags
  logic sel_reg, sel_next; // selected
  logic pau_reg, pau_next; // pause in force
  logic stby_reg, stby_next; // standby
  logic swb_reg, swb_next; // status write blocked
  logic qref_reg, qref_next; // quad asked without quad_enable
  // select and pause flags change with the state, in the same cycle
  always_comb begin
    sel_next = (state_next == SFP_ST_ACTIVE) |
               (state_next == SFP_ST_PAUSED);
    pau_next = (state_next == SFP_ST_PAUSED);
    // an erase or program run keeps the part awake
    stby_next = ~sel_next & ~busy_i;
    // pin guard; frozen protect bits keep their region covered
    swb_next = status_protect_i & ~wp_n_s;
    qref_next = quad_req & ~quad_enable_i;
  end

  // flag registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_reg <= 1'b0;
      pau_reg <= 1'b0;
      stby_reg <= 1'b0;
      swb_reg <= 1'b0;
      qref_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      pau_reg <= pau_next;
      stby_reg <= stby_next;
      swb_reg <= swb_next;
      qref_reg <= qref_next;
    end
  end
  // ==========================================================
  // outputs, all straight from flops
  assign pins_o = '{io: io_out_reg, oe: oe_reg};
  assign rx_byte_o = rx_byte_reg;
  assign rx_valid_o = rx_valid_reg;
  assign rx_first_o = rx_first_reg;
  assign tx_req_o = tx_req_reg;
  assign frame_abort_o = abort_reg;
  assign selected_o = sel_reg;
  assign paused_o = pau_reg;
  assign standby_o = stby_reg;
  assign status_write_block_o = swb_reg;
  assign quad_refused_o = qref_reg;

endmodule

// [design/sfp_pkg.sv]
// shared types and constants of the serial flash pin front end
// assumes a single system clock well above the serial clock rate
package sfp_pkg;

  // ==========================================================
  // data widths
  // ==========================================================
  localparam int SFP_BYTE_W = 8; // bits per shifted byte
  localparam int SFP_LANES = 4; // bidirectional data lines
  localparam int SFP_SYNC_W = 6; // cs_n, sclk and four data lines

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [2:0] SFP_BIT_CNT_RST = 3'h0; // bit position in byte
  localparam logic [7:0] SFP_BYTE_RST = 8'h00; // shift registers
  localparam logic [3:0] SFP_LANE_RST = 4'h0; // pin outputs and enables
  localparam logic [5:0] SFP_SYNC_RST = 6'h00; // select low: reset never arms

  // ==========================================================
  // sync vector field positions
  // ==========================================================
  localparam int SFP_POS_CS = 5;
  localparam int SFP_POS_SCLK = 4;

  // ==========================================================
  // lane width requested by the instruction decoder
  // ==========================================================
  typedef enum logic [1:0] {
    SFP_LANE_SINGLE = 2'h0, // serial_in in, data_line_1 out
    SFP_LANE_DUAL = 2'h1, // data_line_0 and data_line_1
    SFP_LANE_QUAD = 2'h2 // data_line_0 to data_line_3
  } sfp_lane_t;

  // ==========================================================
  // link state, gray coded along power-up, idle, active, paused
  // ==========================================================
  typedef enum logic [1:0] {
    SFP_ST_POWERUP = 2'h2, // waiting to see chip select high
    SFP_ST_IDLE = 2'h0, // deselected, armed
    SFP_ST_ACTIVE = 2'h1, // selected and shifting
    SFP_ST_PAUSED = 2'h3 // selected, pause in force
  } sfp_state_t;

  // ==========================================================
  // pin carriers
  // ==========================================================
  typedef struct packed {
    logic cs_n; // chip select, active low
    logic sclk; // serial clock from the host
    logic [3:0] io; // data_line_3 .. data_line_0 as seen on the pins
  } sfp_pins_in_t;

  typedef struct packed {
    logic [3:0] io; // driven level of data_line_3 .. data_line_0
    logic [3:0] oe; // high while the line is driven
  } sfp_pins_out_t;

endpackage

// [sim/sfp_pin_front_monitor.sv]
// checker of the serial flash pin front, watching top ports only
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ns
module sfp_pin_front_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire sfp_pkg::sfp_pins_in_t pins_i,
  input wire sfp_pkg::sfp_pins_out_t pins_o,
  input wire logic quad_enable_i,
  input wire logic quad_instruction_mode_i,
  input wire sfp_pkg::sfp_lane_t lane_mode_i,
  input wire logic busy_i,
  input wire logic status_protect_i,
  input wire logic rx_valid_o,
  input wire logic tx_req_o,
  input wire logic frame_abort_o,
  input wire logic selected_o,
  input wire logic paused_o,
  input wire logic standby_o,
  input wire logic status_write_block_o,
  input wire logic quad_refused_o
);
  import sfp_pkg::*;
  // ==========
  // arming flag
  // ==========
  logic armed_reg; // select seen high since reset
  logic armed_next;
  // raw pin is enough: a byte can never beat the synchroniser
  always_comb begin
    armed_next = armed_reg | pins_i.cs_n;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // properties
  // ==========
  AST_DESEL_FLOAT: assert property (
    pins_i.cs_n [*6] |-> pins_o.oe == 4'h0)
    else $error("data line driven while deselected");
  AST_STANDBY_BUSY: assert property (
    busy_i [*3] |-> !standby_o) else $error("standby during busy");
  AST_STANDBY_IDLE: assert property (
    (pins_i.cs_n && !busy_i) [*6] |-> standby_o)
    else $error("no standby when idle");
  AST_DESEL_STATE: assert property (
    pins_i.cs_n [*6] |-> !selected_o && !paused_o)
    else $error("still selected after select high");
  AST_NO_RX_BEFORE_ARM: assert property (
    rx_valid_o |-> armed_reg) else $error("byte before first select");
  AST_PAUSE_FLOAT: assert property (
    paused_o ##1 paused_o |-> pins_o.oe == 4'h0)
    else $error("output driven while paused");
  AST_QE_NO_PAUSE: assert property (
    quad_enable_i [*4] |-> !paused_o) else $error("pause with quad");
  AST_WP_BLOCK: assert property (
    (status_protect_i && !pins_i.io[2] && !quad_enable_i) [*5]
    |-> status_write_block_o) else $error("status write not blocked");
  AST_QE_NO_WP: assert property (
    quad_enable_i [*3] |-> !status_write_block_o)
    else $error("protect pin active with quad");
  AST_QUAD_REFUSE: assert property (
    (!quad_enable_i && (lane_mode_i == SFP_LANE_QUAD ||
    quad_instruction_mode_i)) [*3] |-> quad_refused_o)
    else $error("quad not refused");
  AST_NARROW_LANES: assert property (
    !quad_enable_i [*3] |-> pins_o.oe[3:2] == 2'h0)
    else $error("upper lines driven without quad");
  CV_RX: cover property (rx_valid_o);
  CV_TX: cover property (tx_req_o);
  CV_PAUSE: cover property (paused_o);
  CV_ABORT: cover property (frame_abort_o);
endmodule
bind sfp_pin_front sfp_pin_front_monitor sfp_pin_front_monitor_i (
  .clk_i, .resetn_i, .pins_i, .pins_o, .quad_enable_i,
  .quad_instruction_mode_i, .lane_mode_i, .busy_i, .status_protect_i,
  .rx_valid_o, .tx_req_o, .frame_abort_o, .selected_o, .paused_o,
  .standby_o, .status_write_block_o, .quad_refused_o);

// [sim/sfp_host_model.sv]
// host controller model: select, serial clock and data lines
// assumes the bench resolves each line from both drivers' enables
`timescale 1ns/1ns
module sfp_host_model (
  input wire logic [3:0] io_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o,
  output logic [3:0] oe_o
);
  logic cpol = 1'b0; // 1 gives a clock idling high
  logic [1:0] pin_lv = 2'h3; // pause and protect levels
  // select low from power-up must not count as a select edge
  initial begin
    cs_n_o = 1'b0;
    sclk_o = 1'b0;
    io_o = 4'hc;
    oe_o = 4'hc;
  end
  // clock settles at idle level before select falls
  task sel;
    sclk_o = cpol;
    #80 cs_n_o = 1'b1;
    #80 cs_n_o = 1'b0;
    #80;
  endtask
  task desel;
    #80 cs_n_o = 1'b1;
    oe_o = 4'hc;
    io_o[3:2] = pin_lv;
    #160;
  endtask
  task pins_set(input logic [1:0] lv);
    pin_lv = lv;
    io_o[3:2] = lv;
  endtask
  // data set at the fall, sampled at the rise, msb first
  task automatic xfer(input int w, input bit rd, input int nb,
                      input logic [7:0] tx, output logic [7:0] rx);
    logic [3:0] m;
    logic [3:0] c;
    m = 4'((1 << w) - 1);
    if (rd && w == 1) m = 4'h2;
    oe_o = rd ? oe_o & ~m : oe_o | m;
    rx = 8'h00;
    for (int i = 0; i < nb; i += w) begin
      c = 4'((tx >> (nb - i - w)) & ((1 << w) - 1));
      sclk_o = 1'b0;
      if (!rd) io_o = (io_o & ~m) | (c & m);
      #80 sclk_o = 1'b1;
      c = (io_i & m) >> (m == 4'h2);
      rx = 8'((rx << w) | c);
      #80 sclk_o = cpol;
    end
  endtask
endmodule

// [sim/test_sfp_pin_front.sv]
// testbench of the serial flash pin front with a host model
// assumes 125 MHz system clock and a 160 ns serial clock
`timescale 1ns/1ns
module test_sfp_pin_front;
  import sfp_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic qe = 1'b0, quad_instruction_mode = 1'b0, tx_en = 1'b0, busy = 1'b0, sp = 1'b0;
  sfp_lane_t lane = SFP_LANE_SINGLE;
  logic [7:0] tx_byte = 8'h00, rx_byte;
  logic rx_valid, rx_first, tx_req, abort, sel, paused, standby;
  logic blk, refused, h_cs, h_sclk;
  logic [3:0] h_io, h_oe, io_w, flip = 4'h5; // flip: floating lines
  sfp_pins_in_t pins;
  sfp_pins_out_t po;
  logic [8:0] exp_q[$]; // first flag and byte
  logic [8:0] e;
  int mismatches = 0, n_checks = 0, n_req = 0, n_abort = 0, cycles = 0;
  int seed = 58914;
  bit first;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) flip <= ~flip;
  assign io_w = (po.oe & po.io) | (~po.oe & h_oe & h_io) |
                (~po.oe & ~h_oe & flip);
  assign pins = '{cs_n: h_cs, sclk: h_sclk, io: io_w};
  sfp_pin_front sfp_pin_front_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .pins_i(pins), .pins_o(po), .quad_enable_i(qe),
    .quad_instruction_mode_i(quad_instruction_mode), .lane_mode_i(lane), .tx_en_i(tx_en),
    .tx_byte_i(tx_byte), .busy_i(busy), .status_protect_i(sp),
    .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .rx_first_o(rx_first),
    .tx_req_o(tx_req), .frame_abort_o(abort), .selected_o(sel),
    .paused_o(paused), .standby_o(standby),
    .status_write_block_o(blk), .quad_refused_o(refused));
  sfp_host_model sfp_host_model_i (.io_i(io_w), .cs_n_o(h_cs),
    .sclk_o(h_sclk), .io_o(h_io), .oe_o(h_oe));
  // ==========
  // compares and closing
  // ==========
  task cmp_byte(input logic [7:0] g, input logic [7:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task cmp_bit(input logic g, input logic x);
    cmp_byte({7'h00, g}, {7'h00, x});
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // watchdog: a hang counts as a mismatch and ends the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out;
    end
  end
  // reference model: every received byte pops the queue
  always @(posedge clk_i) begin
    if (tx_req === 1'b1) begin
      tx_en <= 1'b0;
      n_req++;
    end
    if (abort === 1'b1) n_abort++;
    if (rx_valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 9'h1_ff;
      cmp_byte(rx_byte, e[7:0]);
      cmp_bit(rx_first, e[8]);
    end
  end
  task wr(input int w, input logic [7:0] b);
    logic [7:0] r;
    exp_q.push_back({first, b});
    first = 1'b0;
    sfp_host_model_i.xfer(w, 1'b0, 8, b, r);
  endtask
  // two bytes in, then one byte out
  task frame(input int w, input bit cp);
    logic [7:0] t, r;
    sfp_host_model_i.cpol = cp;
    sfp_host_model_i.sel();
    cmp_bit(sel, 1'b1);
    first = 1'b1;
    wr(w, 8'($random(seed)));
    @(posedge clk_i);
    t = 8'($random(seed));
    tx_en <= 1'b1;
    tx_byte <= t;
    #1;
    wr(w, 8'($random(seed)));
    sfp_host_model_i.xfer(w, 1'b1, 8, 8'h00, r);
    cmp_byte(r, t);
    sfp_host_model_i.desel();
  endtask
  initial begin
    logic [7:0] b, r;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    wt(4);
    sfp_host_model_i.xfer(1, 1'b0, 8, 8'ha5, r);
    sfp_host_model_i.desel();
    cmp_bit(standby, 1'b1);
    @(posedge clk_i);
    busy <= 1'b1;
    wt(4);
    cmp_bit(standby, 1'b0);
    @(posedge clk_i);
    busy <= 1'b0;
    $display("test powerup done");
    for (int cp = 0; cp < 2; cp++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk_i);
        lane <= sfp_lane_t'(k > 2 ? 2 : k);
        qe <= k > 1;
        quad_instruction_mode <= k == 3;
        wt(2);
        frame(k > 1 ? 4 : k + 1, cp[0]);
      end
    end
    cmp_byte(8'(n_req), 8'h08);
    @(posedge clk_i);
    lane <= SFP_LANE_SINGLE;
    qe <= 1'b0;
    quad_instruction_mode <= 1'b0;
    #1;
    $display("test modes done");
    sfp_host_model_i.cpol = 1'b0;
    sfp_host_model_i.sel();
    b = 8'($random(seed));
    exp_q.push_back({1'b1, b});
    sfp_host_model_i.xfer(1, 1'b0, 4, {4'h0, b[7:4]}, r);
    sfp_host_model_i.pins_set(2'h1);
    wt(25);
    cmp_bit(paused, 1'b1);
    sfp_host_model_i.xfer(1, 1'b0, 3, 8'h05, r);
    sfp_host_model_i.pins_set(2'h3);
    wt(25);
    cmp_bit(paused, 1'b0);
    sfp_host_model_i.xfer(1, 1'b0, 4, {4'h0, b[3:0]}, r);
    sfp_host_model_i.desel();
    @(posedge clk_i);
    qe <= 1'b1;
    #1;
    sfp_host_model_i.sel();
    sfp_host_model_i.pins_set(2'h1);
    wt(25);
    cmp_bit(paused, 1'b0);
    sfp_host_model_i.pins_set(2'h3);
    sfp_host_model_i.desel();
    $display("test pause done");
    @(posedge clk_i);
    lane <= SFP_LANE_QUAD;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      sp <= i[0];
      qe <= i[2];
      #1;
      sfp_host_model_i.pins_set({1'b1, !i[1]});
      wt(8);
      cmp_bit(blk, i[0] & i[1] & !i[2]);
      cmp_bit(refused, !i[2]);
    end
    @(posedge clk_i);
    lane <= SFP_LANE_SINGLE;
    qe <= 1'b0;
    #1;
    $display("test protect done");
    sfp_host_model_i.sel();
    sfp_host_model_i.xfer(1, 1'b0, 3, 8'h05, r);
    sfp_host_model_i.desel();
    cmp_byte(8'(n_abort), 8'h01);
    frame(1, 1'b0);
    cmp_bit(exp_q.size() == 0, 1'b1);
    $display("test abort done");
    close_out;
  end
endmodule
